// ===== csc_driver_ctrl.sv
`timescale 1ns/10ps
module csc_driver_ctrl (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Software configuration
    input wire csc_pkg::csc_cfg_type i_cfg,
    // Operating state
    input wire logic i_hold_current_zero,
    input wire logic i_vmode_en,
    input wire logic i_standstill,
    // Chopper leg commands: on and polarity (1 high side, 0 low side)
    input wire logic [3:0] i_leg_on,
    input wire logic [3:0] i_leg_level,
    // Current regulation inputs
    input wire logic i_comparator,
    input wire logic i_reg_tick,
    input wire logic i_current_low,
    input wire logic i_tuning,
    input wire logic i_tune_gradient,
    // Bridge gate outputs
    output csc_pkg::csc_bridge_type o_bridge,
    // Comparator after blanking
    output logic o_comp_valid,
    output logic o_blanking,
    // Status readback
    output csc_pkg::csc_tune_type o_tune,
    output logic o_driver_enabled
);
    import csc_pkg::*;

    csc_bridge_type bridge_r;
    csc_bridge_type bridge_nxt;
    csc_bridge_type normal_drive;
    wire [CSC_NUM_LEGS-1:0] normal_hs;
    wire [CSC_NUM_LEGS-1:0] normal_ls;
    logic [CSC_BLANK_W-1:0] blank_cnt_r;
    logic [CSC_BLANK_W-1:0] blank_cnt_nxt;
    logic [CSC_BLANK_W-1:0] blank_load;
    logic [CSC_SCALE_W-1:0] scale_r;
    logic [CSC_SCALE_W-1:0] scale_nxt;
    logic comp_r;
    logic [CSC_TUNE_W-1:0] grad_val;
    logic [CSC_TUNE_W-1:0] ofs_val;

    // Driver enable from the off-time field; nonzero values have no other effect.
    wire driver_en = (i_cfg.off_time_enable != CSC_OFF_TIME_DIS);

    // Standstill option only matters at zero hold current in voltage mode.
    wire ss_active = i_standstill && i_hold_current_zero && i_vmode_en;

    // A leg drives either its high or low switch, never both, so no leg can shoot through.
    for (genvar leg = 0; leg < CSC_NUM_LEGS; leg++) begin : g_leg
        assign normal_hs[leg] = i_leg_on[leg] && i_leg_level[leg];
        assign normal_ls[leg] = i_leg_on[leg] && !i_leg_level[leg];
    end
    assign normal_drive = {normal_hs, normal_ls};

    always_comb begin
        bridge_nxt = '0;
        if (!driver_en) begin
            bridge_nxt = '0;
        end else if (!ss_active) begin
            bridge_nxt = normal_drive;
        end else begin
            unique case (i_cfg.standstill_option)
                CSC_SS_NORMAL: begin
                    bridge_nxt = normal_drive;
                end
                CSC_SS_STANDSTILL_OPTION: begin
                    bridge_nxt = '0;
                end
                CSC_SS_SHORT_LS: begin
                    bridge_nxt.ls = '1;
                end
                CSC_SS_SHORT_HS: begin
                    bridge_nxt.hs = '1;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bridge_r <= '0;
        end else begin
            bridge_r <= bridge_nxt;
        end
    end

    assign o_bridge = bridge_r;
    assign o_driver_enabled = driver_en;

    // Blank period per setting, counted in clock periods.
    wire blank_sel_0 = (i_cfg.blank_time_select == 2'h0);
    wire blank_sel_1 = (i_cfg.blank_time_select == 2'h1);
    wire blank_sel_2 = (i_cfg.blank_time_select == 2'h2);
    assign blank_load = blank_sel_0 ? CSC_BLANK_CYC_0 :
                        blank_sel_1 ? CSC_BLANK_CYC_1 :
                        blank_sel_2 ? CSC_BLANK_CYC_2 :
                        CSC_BLANK_CYC_3;

    // A change of any gate is a switching event; ringing follows it.
    wire switch_event = (bridge_nxt != bridge_r);
    wire blank_busy = (blank_cnt_r != 6'h00);

    // Restarting on each event keeps the mask over back-to-back switching.
    assign blank_cnt_nxt = switch_event ? blank_load :
                           blank_busy ? blank_cnt_r - 6'h01 : 6'h00;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            blank_cnt_r <= 6'h00;
            comp_r <= 1'b0;
        end else begin
            blank_cnt_r <= blank_cnt_nxt;
            comp_r <= i_comparator && !blank_busy && !switch_event;
        end
    end

    assign o_comp_valid = comp_r;
    assign o_blanking = blank_busy;

    // Scale correction is a signed value limited to plus or minus 255.
    wire scale_pos = !scale_r[8] && (scale_r != CSC_SCALE_RST);
    wire scale_neg = scale_r[8];
    wire scale_at_max = (scale_r == CSC_SCALE_MAX);
    wire scale_at_min = (scale_r == CSC_SCALE_MIN);
    wire reg_step = i_reg_tick && i_vmode_en;
    wire tune_step = reg_step && i_tuning;

    always_comb begin
        scale_nxt = scale_r;
        if (!reg_step) begin
            scale_nxt = scale_r;
        end else if (i_tuning) begin
            // Tuned parameters absorb the error so the correction can settle.
            if (scale_pos) begin
                scale_nxt = scale_r - 9'h001;
            end else if (scale_neg) begin
                scale_nxt = scale_r + 9'h001;
            end
        end else if (i_current_low && !scale_at_max) begin
            scale_nxt = scale_r + 9'h001;
        end else if (!i_current_low && !scale_at_min) begin
            scale_nxt = scale_r - 9'h001;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            scale_r <= CSC_SCALE_RST;
        end else begin
            scale_r <= scale_nxt;
        end
    end

    // Only the selected tuned value moves; the other keeps its last result.
    wire grad_up = tune_step && i_tune_gradient && i_current_low;
    wire grad_down = tune_step && i_tune_gradient && !i_current_low;
    wire ofs_up = tune_step && !i_tune_gradient && i_current_low;
    wire ofs_down = tune_step && !i_tune_gradient && !i_current_low;

    // Saturating counters keep tuned values within 0 to 255.
    csc_sat_counter #(
        .WIDTH(CSC_TUNE_W)
    ) u_grad (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_up(grad_up),
        .i_down(grad_down),
        .o_value(grad_val)
    );

    csc_sat_counter #(
        .WIDTH(CSC_TUNE_W)
    ) u_ofs (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_up(ofs_up),
        .i_down(ofs_down),
        .o_value(ofs_val)
    );

    assign o_tune.scale_correction = scale_r;
    assign o_tune.tuned_gradient = grad_val;
    assign o_tune.tuned_offset = ofs_val;
endmodule

// ===== csc_pkg.sv
// Functional notes
// - Standstill option 3 turns on all high-side switches so both coils are shorted as a brake.
// - Standstill_option leaves every switch open so the rotor turns freely, and both short options brake.
// - The scale correction is read-only, reaches magnitude 255, and is frozen when voltage mode is off.
// - While tuning runs, the regulator walks the scale correction toward zero.
// - Tuned gradient and offset are read-only values held within 0 to 255.
// - Off-time value 0 disables the bridge, and any nonzero value changes nothing else.
// - Blank time selects 16, 24, 36 or 54 clocks of comparator masking after each switch event.
// - The standstill option acts only at zero hold current with voltage mode on; 2 shorts via low sides.
package csc_pkg;

    localparam int unsigned CSC_NUM_LEGS = 4;
    localparam int unsigned CSC_BLANK_W = 6;
    localparam int unsigned CSC_TUNE_W = 8;
    localparam int unsigned CSC_SCALE_W = 9;

    // Blank periods in clock cycles for settings 0 to 3.
    localparam logic [5:0] CSC_BLANK_CYC_0 = 6'h10;
    localparam logic [5:0] CSC_BLANK_CYC_1 = 6'h18;
    localparam logic [5:0] CSC_BLANK_CYC_2 = 6'h24;
    localparam logic [5:0] CSC_BLANK_CYC_3 = 6'h36;

    localparam logic [8:0] CSC_SCALE_MAX = 9'h0ff;
    localparam logic [8:0] CSC_SCALE_MIN = 9'h101;
    localparam logic [8:0] CSC_SCALE_RST = 9'h000;
    localparam logic [7:0] CSC_TUNE_RST = 8'h00;
    localparam logic [7:0] CSC_TUNE_MAX = 8'hff;
    localparam logic [3:0] CSC_OFF_TIME_DIS = 4'h0;

    typedef enum logic [1:0] {
        CSC_SS_NORMAL,
        CSC_SS_STANDSTILL_OPTION,
        CSC_SS_SHORT_LS,
        CSC_SS_SHORT_HS
    } csc_standstill_type;

    // Configuration written by software.
    typedef struct packed {
        csc_standstill_type standstill_option;
        logic [3:0] off_time_enable;
        logic [1:0] blank_time_select;
    } csc_cfg_type;

    // Gate commands for legs A1, A2, B1, B2.
    typedef struct packed {
        logic [3:0] hs;
        logic [3:0] ls;
    } csc_bridge_type;

    // Read-only tuning results.
    typedef struct packed {
        logic [8:0] scale_correction;
        logic [7:0] tuned_gradient;
        logic [7:0] tuned_offset;
    } csc_tune_type;

endpackage

// ===== csc_sat_counter.sv
`timescale 1ns/10ps
// Saturating up/down counter used for tuned values.
module csc_sat_counter #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Control
    input wire logic i_up,
    input wire logic i_down,
    // Value
    output logic [WIDTH-1:0] o_value
);
    logic [WIDTH-1:0] value_r;
    logic [WIDTH-1:0] value_nxt;
    wire at_max = &value_r;
    wire at_min = ~|value_r;

    // Saturation keeps the value inside the full unsigned range.
    assign value_nxt = (i_up && !i_down && !at_max) ? value_r + 1'b1 :
                       (i_down && !i_up && !at_min) ? value_r - 1'b1 : value_r;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            value_r <= '0;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign o_value = value_r;
endmodule

// ===== csc_bridge_model.sv
`timescale 1ns/10ps
module csc_bridge_model (
    // Gates
    input wire csc_pkg::csc_bridge_type i_gate,
    // State
    output logic o_shoot,
    output logic o_brake
);
    import csc_pkg::*;
    // A leg with both switches on would short the supply.
    assign o_shoot = |(i_gate.hs & i_gate.ls);
    assign o_brake = i_gate.hs == 4'hf || i_gate.ls == 4'hf;
endmodule

// ===== csc_driver_ctrl_props.sv
`timescale 1ns/10ps
module csc_props (
    // Clock
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Inputs
    input wire csc_pkg::csc_cfg_type i_cfg,
    input wire logic i_hold_current_zero,
    input wire logic i_vmode_en,
    input wire logic i_standstill,
    input wire logic i_reg_tick,
    input wire logic i_current_low,
    input wire logic i_tuning,
    // Outputs
    input wire csc_pkg::csc_bridge_type o_bridge,
    input wire logic o_comp_valid,
    input wire logic o_blanking,
    input wire csc_pkg::csc_tune_type o_tune
);
    import csc_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    wire logic on = i_cfg.off_time_enable != 4'h0;
    wire logic hold = i_standstill && i_hold_current_zero && i_vmode_en && on;
    wire logic [1:0] opt = i_cfg.standstill_option;
    wire logic [8:0] sc = o_tune.scale_correction;
    wire logic neg = sc[8];
    wire logic step = i_reg_tick && i_vmode_en;
    chk_off_bridge: assert property (!on |=> o_bridge == 8'h00)
        else $error("bridge driven while off");
    chk_short_high: assert property (hold && opt == 2'h3 |=> o_bridge == 8'hf0)
        else $error("high short wrong");
    chk_short_low: assert property (hold && opt == 2'h2 |=> o_bridge == 8'h0f)
        else $error("low short wrong");
    chk_free_open: assert property (hold && opt == 2'h1 |=> o_bridge == 8'h00)
        else $error("standstill_option not open");
    chk_scale_frozen: assert property (!i_vmode_en |=> $stable(o_tune))
        else $error("tune moved while frozen");
    chk_tune_zero: assert property (step && i_tuning && sc != 9'h000
        |=> sc == $past(sc) + ($past(neg) ? 9'h001 : 9'h1ff)) else $error("no step to zero");
    chk_scale_up: assert property (step && !i_tuning && i_current_low
        && sc != 9'h0ff |=> sc == $past(sc) + 9'h001) else $error("scale not raised");
    chk_blank_hold: assert property ($changed(o_bridge) |-> ##15 o_blanking)
        else $error("blanking too short");
    chk_comp_masked: assert property (o_blanking |=> !o_comp_valid)
        else $error("comparator passed in blanking");
    cover property (o_bridge == 8'hf0);
    cover property (step && i_tuning);
    cover property ($fell(o_blanking));
endmodule

bind csc_driver_ctrl csc_props i_csc_props (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_cfg(i_cfg),
    .i_hold_current_zero(i_hold_current_zero),
    .i_vmode_en(i_vmode_en),
    .i_standstill(i_standstill),
    .i_reg_tick(i_reg_tick),
    .i_current_low(i_current_low),
    .i_tuning(i_tuning),
    .o_bridge(o_bridge),
    .o_comp_valid(o_comp_valid),
    .o_blanking(o_blanking),
    .o_tune(o_tune)
);

// ===== csc_driver_ctrl_tb.sv
`timescale 1ns/10ps
module csc_driver_ctrl_tb;
    import csc_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    csc_cfg_type cfg = '0;
    logic hz = 0, vm = 0, st = 0, cmp = 0, tk = 0, cl = 0, tn = 0, tg = 0;
    logic [3:0] lo = 4'h0, ll = 4'h0;
    csc_bridge_type br;
    csc_tune_type tu;
    logic cv, bk, en, shoot, brake, ev;
    logic [7:0] eb, nb;
    int blk, sc, gr, of, ecv, fails = 0, compares = 0, cyc = 0;
    int tab[4] = '{16, 24, 36, 54};
    csc_driver_ctrl i_csc_driver_ctrl (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cfg(cfg),
        .i_hold_current_zero(hz), .i_vmode_en(vm), .i_standstill(st), .i_leg_on(lo),
        .i_leg_level(ll), .i_comparator(cmp), .i_reg_tick(tk), .i_current_low(cl),
        .i_tuning(tn), .i_tune_gradient(tg), .o_bridge(br), .o_comp_valid(cv),
        .o_blanking(bk), .o_tune(tu), .o_driver_enabled(en));
    csc_bridge_model i_csc_bridge_model (.i_gate(br), .o_shoot(shoot), .o_brake(brake));
    always #20 i_sys_clk = ~i_sys_clk;
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task close_out;
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function int sat(int v, logic up);
        return up ? (v < 255 ? v + 1 : v) : (v > 0 ? v - 1 : v);
    endfunction
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            eb = 8'h00;
            {blk, sc, gr, of, ecv} = '0;
        end else begin
            chk("bridge", br, eb);
            chk("brake", brake, eb == 8'hf0 || eb == 8'h0f);
            chk("shoot", shoot, 1'b0);
            chk("blanking", bk, blk != 0);
            chk("comp", cv, ecv);
            chk("scale", tu.scale_correction, sc[8:0]);
            chk("gradient", tu.tuned_gradient, gr);
            chk("offset", tu.tuned_offset, of);
            chk("enable", en, cfg.off_time_enable != 4'h0);
            nb = {lo & ll, lo & ~ll};
            if (st && hz && vm && cfg.standstill_option != CSC_SS_NORMAL) begin
                nb = cfg.standstill_option == CSC_SS_SHORT_HS ? 8'hf0 :
                    (cfg.standstill_option == CSC_SS_SHORT_LS ? 8'h0f : 8'h00);
            end
            if (cfg.off_time_enable == 4'h0) nb = 8'h00;
            ev = nb != eb;
            ecv = cmp && blk == 0 && !ev;
            blk = ev ? tab[cfg.blank_time_select] : (blk > 0 ? blk - 1 : 0);
            eb = nb;
            if (tk && vm && !tn) sc = cl ? (sc < 255 ? sc + 1 : sc) : (sc > -255 ? sc - 1 : sc);
            if (tk && vm && tn) begin
                sc = sc > 0 ? sc - 1 : (sc < 0 ? sc + 1 : 0);
                if (tg) gr = sat(gr, cl);
                else of = sat(of, cl);
            end
        end
    end
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 9000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'ha7d02616));
        repeat (20) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        for (int k = 0; k < 64; k++) begin
            @(posedge i_sys_clk);
            // Walk every option and blank setting; some segments keep the driver off.
            cfg <= {k[1:0], (k % 7 == 0) ? 4'h0 : 4'($urandom), k[3:2]};
            {hz, vm, st} <= k[4] ? 3'h7 : 3'($urandom);
            tn <= k[2:0] == 3'h7;
            tg <= k[3];
            repeat (80) begin
                @(posedge i_sys_clk);
                cmp <= 1'($urandom);
                tk <= 1'($urandom);
                // Biased so the scale saturates up first, then down.
                cl <= ($urandom % 4 != 0) ^ k[5];
                if ($urandom % 32 == 0) {lo, ll} <= 8'($urandom);
            end
        end
        close_out();
    end
endmodule
